// ==== core/pss_pkg.sv ====
package pss_pkg;

    // ---------------------------------------------------------------
    // Sizes of the set bank
    // ---------------------------------------------------------------
    localparam int unsigned PSS_SET_COUNT = 64;
    localparam int unsigned PSS_IDX_W     = 6;
    localparam int unsigned PSS_TOT_W     = 7;
    localparam int unsigned PSS_EXEC_W    = 9;
    localparam int unsigned PSS_PARAM_W   = 32;

    // ---------------------------------------------------------------
    // Fixed values
    // ---------------------------------------------------------------
    localparam logic [PSS_IDX_W-1:0]   PSS_FIRST_SET = 6'h00;
    localparam logic [PSS_TOT_W-1:0]   PSS_TOT_MAX   = 7'h40;
    localparam logic [PSS_TOT_W-1:0]   PSS_TOT_MIN   = 7'h01;
    localparam logic [PSS_EXEC_W-1:0]  PSS_USE_RST   = 9'h000;
    localparam logic [PSS_EXEC_W-1:0]  PSS_USE_ONE   = 9'h001;
    localparam logic [PSS_PARAM_W-1:0] PSS_PARAM_RST = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PSS_ST_IDLE  = 2'b00,
        PSS_ST_RUN   = 2'b01,
        PSS_ST_DRAIN = 2'b10
    } pss_state_t;

endpackage

// ==== core/pss_set_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module pss_set_mem
    import pss_pkg::*;
(
    // Clock
    input  wire logic                   core_clk,
    // Store port
    input  wire logic                   wr_en,
    input  wire logic [PSS_IDX_W-1:0]   wr_idx,
    input  wire logic [PSS_PARAM_W-1:0] wr_params,
    input  wire logic [PSS_EXEC_W-1:0]  wr_exec,
    // Read port for loading the active set
    input  wire logic [PSS_IDX_W-1:0]   ld_idx,
    output logic      [PSS_PARAM_W-1:0] ld_params,
    // Read port for the current set's execution count
    input  wire logic [PSS_IDX_W-1:0]   ex_idx,
    output logic      [PSS_EXEC_W-1:0]  ex_exec
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // Volatile like the sets themselves: no reset, contents are
    // undefined until software stores each set it uses.
    logic [PSS_PARAM_W-1:0] param_mem [PSS_SET_COUNT];
    logic [PSS_EXEC_W-1:0]  exec_mem  [PSS_SET_COUNT];

    // Write on store command
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            param_mem[wr_idx] <= wr_params;
            exec_mem[wr_idx]  <= wr_exec;
        end
    end

    // Asynchronous reads so a load lands in one cycle
    assign ld_params = param_mem[ld_idx];
    assign ex_exec   = exec_mem[ex_idx];

endmodule
`default_nettype wire

// ==== core/pss_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module pss_sequencer
    import pss_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Configuration from software
    input  wire logic                   seq_enable,
    input  wire logic [PSS_IDX_W-1:0]   set_select_index,
    input  wire logic [PSS_TOT_W-1:0]   set_total,
    input  wire logic [PSS_EXEC_W-1:0]  set_exec_count,
    input  wire logic                   recall_set_command,
    input  wire logic                   store_set_command,
    input  wire logic                   param_wr_en,
    input  wire logic [PSS_PARAM_W-1:0] param_wr_data,
    // Acquisition side
    input  wire logic                   frame_trigger,
    input  wire logic                   frame_busy,
    // Active set and status
    output logic      [PSS_PARAM_W-1:0] active_params,
    output logic      [PSS_IDX_W-1:0]   current_set,
    output logic      [PSS_EXEC_W-1:0]  use_count,
    output logic                        seq_running
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Clamp the set total to 1..64 so a bad value cannot index
    // past the bank or stall the cycle on an empty range.
    function automatic logic [PSS_TOT_W-1:0] tot_limit
        (input logic [PSS_TOT_W-1:0] t);
        if (t == '0)
            tot_limit = PSS_TOT_MIN;
        else if (t > PSS_TOT_MAX)
            tot_limit = PSS_TOT_MAX;
        else
            tot_limit = t;
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    pss_state_t             state_r, state_nxt;
    logic [PSS_PARAM_W-1:0] active_r, active_nxt;
    logic [PSS_PARAM_W-1:0] saved_r, saved_nxt;
    logic [PSS_IDX_W-1:0]   cur_set_r, cur_set_nxt;
    logic [PSS_EXEC_W-1:0]  use_cnt_r, use_cnt_nxt;

    logic [PSS_TOT_W-1:0]   total_lim;
    logic [PSS_TOT_W-1:0]   cur_plus;
    logic [PSS_IDX_W-1:0]   next_set;
    logic [PSS_IDX_W-1:0]   ld_idx;
    logic [PSS_PARAM_W-1:0] ld_params;
    logic [PSS_EXEC_W-1:0]  cur_exec;
    logic                   reuse;
    logic                   run_trig;

    // ---------------------------------------------------------------
    // Set bank
    // ---------------------------------------------------------------
    // Store only while disabled; the active set is then software's.
    pss_set_mem u_mem (
        .core_clk  (core_clk),
        .wr_en     (store_set_command && (state_r == PSS_ST_IDLE)
                    && !seq_enable),
        .wr_idx    (set_select_index),
        .wr_params (active_r),
        .wr_exec   (set_exec_count),
        .ld_idx    (ld_idx),
        .ld_params (ld_params),
        .ex_idx    (cur_set_r),
        .ex_exec   (cur_exec)
    );

    // Next index and wrap point
    assign total_lim = tot_limit(set_total);
    assign cur_plus  = {1'b0, cur_set_r} + PSS_TOT_MIN;
    assign next_set  = (cur_plus >= total_lim) ? PSS_FIRST_SET
                                               : cur_plus[PSS_IDX_W-1:0];
    assign reuse     = (use_cnt_r < cur_exec);
    assign run_trig  = (state_r == PSS_ST_RUN) && seq_enable
                       && frame_trigger;

    // Load address: selection when idle, set 0 on enable, else next
    always_comb
    begin
        if (state_r != PSS_ST_IDLE)
            ld_idx = next_set;
        else if (seq_enable)
            ld_idx = PSS_FIRST_SET;
        else
            ld_idx = set_select_index;
    end

    // ---------------------------------------------------------------
    // Sequencer next state
    // ---------------------------------------------------------------
    always_comb
    begin
        state_nxt   = state_r;
        active_nxt  = active_r;
        saved_nxt   = saved_r;
        cur_set_nxt = cur_set_r;
        use_cnt_nxt = use_cnt_r;
        case (state_r)
            PSS_ST_IDLE:
            begin
                if (seq_enable)
                begin
                    // Keep the original values for the restore
                    saved_nxt   = active_r;
                    active_nxt  = ld_params;
                    cur_set_nxt = PSS_FIRST_SET;
                    use_cnt_nxt = PSS_USE_RST;
                    state_nxt   = PSS_ST_RUN;
                end
                else if (recall_set_command)
                    active_nxt = ld_params;
                else if (param_wr_en)
                    active_nxt = param_wr_data;
            end
            PSS_ST_RUN:
            begin
                // Disable wins over a trigger in the same cycle
                if (!seq_enable)
                begin
                    if (frame_busy)
                        state_nxt = PSS_ST_DRAIN;
                    else
                    begin
                        active_nxt = saved_r;
                        state_nxt  = PSS_ST_IDLE;
                    end
                end
                else if (frame_trigger)
                begin
                    if (reuse)
                        use_cnt_nxt = use_cnt_r + PSS_USE_ONE;
                    else
                    begin
                        cur_set_nxt = next_set;
                        active_nxt  = ld_params;
                        use_cnt_nxt = PSS_USE_ONE;
                    end
                end
            end
            PSS_ST_DRAIN:
            begin
                // Set stays put until the last frame is out
                if (!frame_busy)
                begin
                    active_nxt = saved_r;
                    state_nxt  = PSS_ST_IDLE;
                end
            end
            default:
                state_nxt = PSS_ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // Sequencer registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r   <= PSS_ST_IDLE;
            active_r  <= PSS_PARAM_RST;
            saved_r   <= PSS_PARAM_RST;
            cur_set_r <= PSS_FIRST_SET;
            use_cnt_r <= PSS_USE_RST;
        end
        else
        begin
            state_r   <= state_nxt;
            active_r  <= active_nxt;
            saved_r   <= saved_nxt;
            cur_set_r <= cur_set_nxt;
            use_cnt_r <= use_cnt_nxt;
        end
    end

    // Outputs
    assign active_params = active_r;
    assign current_set   = cur_set_r;
    assign use_count     = use_cnt_r;
    assign seq_running   = (state_r != PSS_ST_IDLE);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_recall_copy: assert property (@(posedge core_clk)
        disable iff (rst)
        (state_r == PSS_ST_IDLE) && !seq_enable && recall_set_command
        |=> active_r == $past(ld_params))
        else $error("recall did not copy stored set");

    a_enable_load: assert property (@(posedge core_clk)
        disable iff (rst)
        (state_r == PSS_ST_IDLE) && seq_enable
        |=> (cur_set_r == PSS_FIRST_SET) && (use_cnt_r == PSS_USE_RST)
            && (active_r == $past(ld_params)))
        else $error("enable did not load set 0");

    a_step_up: assert property (@(posedge core_clk) disable iff (rst)
        run_trig && !reuse
        |=> (cur_set_r == $past(cur_set_r) + 6'h01)
            || (($past(cur_plus) >= $past(total_lim))
                && (cur_set_r == PSS_FIRST_SET)))
        else $error("advance did not step upward");

    a_reuse_hold: assert property (@(posedge core_clk) disable iff (rst)
        run_trig && reuse
        |=> $stable(cur_set_r) && (use_cnt_r == $past(use_cnt_r) + 9'h001))
        else $error("set not reused while below count");

    a_wrap_zero: assert property (@(posedge core_clk) disable iff (rst)
        run_trig && !reuse && (cur_plus >= total_lim)
        |=> cur_set_r == PSS_FIRST_SET)
        else $error("cycle did not wrap to set 0");

    a_set_range: assert property (@(posedge core_clk) disable iff (rst)
        run_trig
        |=> {1'b0, cur_set_r} < $past(total_lim))
        else $error("set index beyond total");

    a_drain_hold: assert property (@(posedge core_clk) disable iff (rst)
        (state_r == PSS_ST_DRAIN) && frame_busy
        |=> (state_r == PSS_ST_DRAIN) && $stable(active_r)
            && $stable(cur_set_r))
        else $error("frame not finished before stop");

    a_restore_orig: assert property (@(posedge core_clk)
        disable iff (rst)
        (state_r != PSS_ST_IDLE) && (state_nxt == PSS_ST_IDLE)
        |=> active_r == $past(saved_r))
        else $error("original values not restored");

    a_use_clear: assert property (@(posedge core_clk) disable iff (rst)
        run_trig && !reuse
        |=> use_cnt_r == PSS_USE_ONE)
        else $error("use counter not restarted");

endmodule
`default_nettype wire

// ==== tb/pss_frame_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module pss_frame_src
#(
    parameter int unsigned BUSY_LEN = 6
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Request from the bench
    input  wire logic fire,
    // Frame start side
    output logic      frame_trigger,
    output logic      frame_busy
);

    // ---------------------------------------------------------------
    // Frame source: one trigger pulse, then exposure and readout
    // ---------------------------------------------------------------
    logic [3:0] busy_cnt_r;

    // A new trigger restarts the busy window, like a fresh frame
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            frame_trigger <= 1'b0;
            busy_cnt_r    <= 4'h0;
        end
        else
        begin
            frame_trigger <= fire;
            if (fire)
                busy_cnt_r <= 4'(BUSY_LEN);
            else if (busy_cnt_r != 4'h0)
                busy_cnt_r <= busy_cnt_r - 4'h1;
        end
    end

    assign frame_busy = (busy_cnt_r != 4'h0);

endmodule

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
    begin \
        checked = checked + 1; \
        if ((got) !== (ex)) \
        begin \
            fail_count = fail_count + 1; \
            $display("unexpected %s expected %h seen %h", nm, ex, got); \
        end \
    end

module tb
    import pss_pkg::*;
;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic                   core_clk, rst, seq_enable, fire;
    logic                   recall_set_command, store_set_command;
    logic                   param_wr_en, frame_trigger, frame_busy;
    logic [PSS_IDX_W-1:0]   set_select_index, current_set;
    logic [PSS_TOT_W-1:0]   set_total;
    logic [PSS_EXEC_W-1:0]  set_exec_count, use_count;
    logic [PSS_PARAM_W-1:0] param_wr_data, active_params;
    logic                   seq_running;
    int                     fail_count, checked, cycles, n;

    localparam logic [PSS_PARAM_W-1:0] ORIG = 32'h1234_5678;
    // Per-set execution counts, as in the six-set example
    localparam logic [8:0] EXECS [6] = '{9'h001, 9'h003, 9'h001,
                                         9'h001, 9'h001, 9'h002};
    // Rows: expected {current_set, use_count} after each trigger
    localparam logic [14:0] ROWS [10] = '{15'h0001, 15'h0201, 15'h0202,
        15'h0203, 15'h0401, 15'h0601, 15'h0801, 15'h0A01, 15'h0A02,
        15'h0001};

    // ---------------------------------------------------------------
    // Design, frame source, clock and timeout
    // ---------------------------------------------------------------
    pss_sequencer u_dut (.core_clk(core_clk), .rst(rst),
        .seq_enable(seq_enable), .set_select_index(set_select_index),
        .set_total(set_total), .set_exec_count(set_exec_count),
        .recall_set_command(recall_set_command),
        .store_set_command(store_set_command), .param_wr_en(param_wr_en),
        .param_wr_data(param_wr_data), .frame_trigger(frame_trigger),
        .frame_busy(frame_busy), .active_params(active_params),
        .current_set(current_set), .use_count(use_count),
        .seq_running(seq_running));

    pss_frame_src #(.BUSY_LEN(6)) u_src (.core_clk(core_clk), .rst(rst),
        .fire(fire), .frame_trigger(frame_trigger),
        .frame_busy(frame_busy));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Whole run is about a hundred cycles; this only catches a hang
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    function automatic logic [PSS_PARAM_W-1:0] pv(input logic [5:0] k);
        return 32'hC0DE_0000 | 32'(k);
    endfunction

    // Config pulses last one cycle; outputs are checked once landed
    task automatic cfg(input logic rc, sc, pw, input logic [5:0] ix,
                       input logic [31:0] d, input logic [8:0] ex);
        @(posedge core_clk);
        recall_set_command <= rc;
        store_set_command  <= sc;
        param_wr_en        <= pw;
        set_select_index   <= ix;
        param_wr_data      <= d;
        set_exec_count     <= ex;
        @(posedge core_clk);
        recall_set_command <= 1'b0;
        store_set_command  <= 1'b0;
        param_wr_en        <= 1'b0;
        #1;
    endtask

    // Source needs one edge to raise the trigger, the design one more
    task automatic trig();
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic en(input logic v);
        @(posedge core_clk);
        seq_enable <= v;
        @(posedge core_clk);
        #1;
    endtask

    task automatic wait_idle();
        n = 0;
        while (seq_running !== 1'b0 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n = n + 1;
        end
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {rst, seq_enable, fire, recall_set_command} = 4'h8;
        {store_set_command, param_wr_en} = 2'b00;
        set_select_index = 6'h00;
        set_total        = 7'h06;
        set_exec_count   = 9'h001;
        param_wr_data    = 32'h0000_0000;
        fail_count = 0;
        checked    = 0;
        cycles     = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // Fill sets 0..5 while the sequencer is off
        for (int k = 0; k < 6; k++)
        begin
            cfg(1'b0, 1'b0, 1'b1, 6'(k), pv(6'(k)), 9'h001);
            cfg(1'b0, 1'b1, 1'b0, 6'(k), pv(6'(k)), EXECS[k]);
        end
        cfg(1'b1, 1'b0, 1'b0, 6'h02, 32'h0000_0000, 9'h001);
        `CHK("recall", pv(6'h02), active_params)
        cfg(1'b0, 1'b0, 1'b1, 6'h00, ORIG, 9'h001);
        en(1'b1);
        `CHK("enable set", pv(6'h00), active_params)
        `CHK("enable idx", 6'h00, current_set)
        `CHK("enable use", 9'h000, use_count)
        for (int r = 0; r < 10; r++)
        begin
            trig();
            `CHK("row set", ROWS[r][14:9], current_set)
            `CHK("row use", ROWS[r][8:0], use_count)
            `CHK("row params", pv(ROWS[r][14:9]), active_params)
        end
        // Recall and write while running must leave the active set
        cfg(1'b1, 1'b0, 1'b1, 6'h03, 32'hDEAD_BEEF, 9'h001);
        `CHK("refused", pv(6'h00), active_params)
        // Disable in mid-frame, with a trigger during the drain
        trig();
        en(1'b0);
        `CHK("drain run", 1'b1, seq_running)
        trig();
        `CHK("drain set", 6'h01, current_set)
        `CHK("drain params", pv(6'h01), active_params)
        wait_idle();
        `CHK("stopped", 1'b0, seq_running)
        `CHK("restored", ORIG, active_params)
        // Total of 0 clamps to a one-set cycle
        @(posedge core_clk);
        set_total <= 7'h00;
        en(1'b1);
        trig();
        trig();
        `CHK("clamp set", 6'h00, current_set)
        `CHK("clamp use", 9'h001, use_count)
        en(1'b0);
        wait_idle();
        `CHK("restored 2", ORIG, active_params)
        // Reset in mid-run: outputs clear, the set bank survives
        en(1'b1);
        trig();
        @(posedge core_clk);
        rst        <= 1'b1;
        seq_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("reset run", 1'b0, seq_running)
        `CHK("reset set", PSS_FIRST_SET, current_set)
        `CHK("reset use", PSS_USE_RST, use_count)
        `CHK("reset params", PSS_PARAM_RST, active_params)
        // Enable at the first edge after release is taken
        @(posedge core_clk);
        rst        <= 1'b0;
        seq_enable <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("post reset run", 1'b1, seq_running)
        `CHK("post reset set", pv(6'h00), active_params)
        `CHK("post reset use", PSS_USE_RST, use_count)
        en(1'b0);
        wait_idle();
        `CHK("restored 3", PSS_PARAM_RST, active_params)
        end_of_test();
    end

endmodule

`default_nettype wire
